// *** dv/rtc_muxed_host_bus_and_pins_bench.sv ***
// self-checking bench for the clock device host port and pins
`timescale 1ns/10ps
`default_nettype none
module rtc_muxed_host_bus_and_pins_bench;
  typedef struct packed { logic up; logic [7:0] a; logic [7:0] d; } rtcp_row_t;
  logic        clk, rst_n, dev_rst_n, style, supply, xtal, wipe_n;
  logic        as_s, ds_s, rw_s, cs_n, up_s, oe_n, irq_n, irq_oe_n, square_wave_out, irq_line;
  logic [2:0]  evt;
  logic [15:0] taps;
  logic [7:0]  h_ad, ad_i, ad_o, v;
  int          num_errors, tests_run;
  rtcp_row_t   rows [6];

  // open-drain interrupt line with its pull-up
  assign irq_line = irq_oe_n ? 1'b1 : irq_n;
  assign ad_i = oe_n ? h_ad : ad_o;

  rtcp_host_model i_host (
    .sys_clk_i(clk), .style_i(style), .as_o(as_s), .ds_o(ds_s), .rw_o(rw_s),
    .cs_n_o(cs_n), .upper_o(up_s), .ad_o(h_ad), .ad_i(ad_i), .oe_n_i(oe_n)
  );

  // short wipe count keeps the hold test brief
  rtcp_host_port #(.WIPE_CYC(20)) i_dut (
    .sys_clk_i(clk), .reset_n_i(rst_n), .dev_reset_n_i(dev_rst_n),
    .bus_style_select_i(style), .supply_valid_i(supply),
    .muxed_addr_data_lines_i(ad_i), .muxed_addr_data_lines_o(ad_o),
    .muxed_addr_data_lines_oe_n_o(oe_n), .address_latch_strobe_i(as_s),
    .data_strobe_input_i(ds_s), .rd_wr_n_i(rw_s), .chip_sel_n_i(cs_n),
    .upper_ram_select_i(up_s), .periodic_evt_i(evt[2]), .alarm_evt_i(evt[1]),
    .update_evt_i(evt[0]), .divider_taps_i(taps), .crystal_input_one_i(xtal),
    .storage_wipe_n_i(wipe_n), .irq_n_o(irq_n), .irq_n_oe_n_o(irq_oe_n),
    .square_wave_out_o(square_wave_out)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, got, exp);
    end
  endtask

  task give_verdict();
    num_errors += i_host.timeouts;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task wr(input logic up, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    i_host.acc(1'b1, up, a, d, x);
  endtask

  task rd(input logic up, input logic [7:0] a, input logic [7:0] e);
    i_host.acc(1'b0, up, a, 8'h00, v);
    chk(v, e);
  endtask

  // bounded wait for a pin level, then compare it
  task wl(input logic sq, input logic e);
    int k;
    k = 0;
    while (((sq ? square_wave_out : irq_line) !== e) && k < 30) begin
      @(negedge clk);
      k++;
    end
    chk({7'h00, sq ? square_wave_out : irq_line}, {7'h00, e});
  endtask

  task pulse(input logic [2:0] p);
    evt = p;
    @(negedge clk);
    evt = 3'b000;
  endtask

  task do_reset(input logic s);
    rst_n = 1'b0; style = s;
    repeat (16) @(negedge clk);
    i_host.idle();
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    give_verdict();
  end

  initial begin
    num_errors = 0; tests_run = 0; dev_rst_n = 1'b1; supply = 1'b1; xtal = 1'b0;
    wipe_n = 1'b1; evt = 3'b000; taps = 16'h0000;
    rows = '{'{1'b0, 8'h0e, 8'h3c}, '{1'b0, 8'hff, 8'ha5}, '{1'b1, 8'h10, 8'h81},
             '{1'b0, 8'h10, 8'h7e}, '{1'b1, 8'h7f, 8'h42}, '{1'b0, 8'h0a, 8'h25}};
    do_reset(1'b1);
    chk({5'h00, oe_n, irq_oe_n, square_wave_out}, 8'h06);
    foreach (rows[i]) rd(1'b0, 8'h0a + 8'(i % 3), 8'h00);
    $display("reset test done");
    // all writes first so that an aliased page shows up on read back
    foreach (rows[i]) wr(rows[i].up, rows[i].a, rows[i].d);
    foreach (rows[i]) rd(rows[i].up, rows[i].a, rows[i].d);
    $display("row test done");
    // each source alone: flag, summary flag, pin, clear on read
    for (int i = 0; i < 3; i++) begin
      wr(1'b0, 8'h0b, 8'h40 >> i);
      pulse(3'b100 >> i);
      wl(1'b0, 1'b0);
      rd(1'b0, 8'h0c, 8'h80 | (8'h40 >> i));
      wl(1'b0, 1'b1);
      rd(1'b0, 8'h0c, 8'h00);
    end
    wr(1'b0, 8'h0b, 8'h00);
    pulse(3'b100);
    wl(1'b0, 1'b1);
    rd(1'b0, 8'h0c, 8'h40);
    $display("interrupt test done");
    taps = 16'h0020;
    wl(1'b1, 1'b0);
    wr(1'b0, 8'h0b, 8'h08);
    wl(1'b1, 1'b1);
    taps = 16'hffdf;
    wl(1'b1, 1'b0);
    wr(1'b0, 8'h0a, 8'h30);
    wr(1'b0, 8'h0c, 8'h01);
    xtal = 1'b1;
    wl(1'b1, 1'b1);
    xtal = 1'b0;
    wl(1'b1, 1'b0);
    xtal = 1'b1;
    supply = 1'b0;
    wl(1'b1, 1'b0);
    $display("square wave test done");
    supply = 1'b1;
    wr(1'b0, 8'h0b, 8'h20);
    wr(1'b0, 8'h0c, 8'h00);
    supply = 1'b0;
    wr(1'b0, 8'h0e, 8'h11);
    pulse(3'b010);
    wl(1'b0, 1'b0);
    supply = 1'b1;
    rd(1'b0, 8'h0e, 8'h3c);
    rd(1'b0, 8'h0c, 8'ha0);
    $display("supply fail test done");
    wipe_n = 1'b0;
    repeat (10) @(negedge clk);
    wipe_n = 1'b1;
    rd(1'b0, 8'h0e, 8'h3c);
    wipe_n = 1'b0;
    repeat (40) @(negedge clk);
    wipe_n = 1'b1;
    // the walk over 242 bytes outlasts the pin hold
    repeat (300) @(negedge clk);
    rd(1'b0, 8'h0e, 8'hff);
    rd(1'b0, 8'hff, 8'hff);
    rd(1'b1, 8'h10, 8'h81);
    rd(1'b0, 8'h0a, 8'h30);
    $display("wipe test done");
    i_host.skip_cs = 1'b1;
    wr(1'b0, 8'h0e, 8'h99);
    i_host.skip_cs = 1'b0;
    rd(1'b0, 8'h0e, 8'hff);
    wr(1'b0, 8'h0b, 8'h70);
    pulse(3'b100);
    wl(1'b0, 1'b0);
    dev_rst_n = 1'b0;
    wl(1'b0, 1'b1);
    wr(1'b0, 8'h0e, 8'h77);
    dev_rst_n = 1'b1;
    rd(1'b0, 8'h0e, 8'hff);
    rd(1'b0, 8'h0b, 8'h00);
    rd(1'b0, 8'h0c, 8'h00);
    $display("refusal test done");
    do_reset(1'b0);
    wr(1'b0, 8'h20, 8'h6b);
    rd(1'b0, 8'h20, 8'h6b);
    wr(1'b1, 8'h05, 8'h94);
    rd(1'b1, 8'h05, 8'h94);
    rd(1'b0, 8'h0a, 8'h00);
    $display("split strobe test done");
    give_verdict();
  end
endmodule
`default_nettype wire

// *** dv/rtcp_host_model.sv ***
// host bus master model driving the multiplexed port pins
`timescale 1ns/10ps
`default_nettype none
module rtcp_host_model (
  // clock and strap seen by the host
  input  wire logic       sys_clk_i,
  input  wire logic       style_i,
  // bus pins
  output logic            as_o,
  output logic            ds_o,
  output logic            rw_o,
  output logic            cs_n_o,
  output logic            upper_o,
  output logic      [7:0] ad_o,
  input  wire logic [7:0] ad_i,
  input  wire logic       oe_n_i
);
  logic       drv;
  logic       skip_cs;
  logic [7:0] d;
  logic [7:0] junk;
  int         timeouts;

  // a released bus flips every cycle so stale data never looks valid
  assign ad_o = drv ? d : junk;
  always @(negedge sys_clk_i) begin
    junk <= ~junk;
  end

  initial begin
    as_o = 1'b0; ds_o = 1'b1; rw_o = 1'b1; cs_n_o = 1'b1; upper_o = 1'b0;
    drv = 1'b0; skip_cs = 1'b0; d = 8'h00; junk = 8'h5a; timeouts = 0;
  end

  // idle strobe levels follow the strap: data strobe idles low in strobe style
  task idle();
    ds_o = ~style_i;
    rw_o = 1'b1;
  endtask

  task wt(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  // one whole bus cycle: address phase, then one data phase
  task acc(input logic wr, input logic up, input logic [7:0] a, input logic [7:0] wd,
           output logic [7:0] rd);
    int k;
    rd = 8'h00;
    d = a; drv = 1'b1; upper_o = up; as_o = 1'b1;
    wt(6);
    as_o = 1'b0;
    wt(6);
    drv = wr; d = wd;
    cs_n_o = skip_cs;
    rw_o = style_i ? ~wr : 1'b1;
    wt(2);
    if (style_i) ds_o = 1'b1;
    else if (wr) rw_o = 1'b0;
    else ds_o = 1'b0;
    if (!wr) begin
      k = 0;
      while (oe_n_i !== 1'b0 && k < 40) begin
        @(negedge sys_clk_i);
        k++;
      end
      if (k >= 40 && !skip_cs) timeouts++;
      rd = ad_i;
    end
    wt(8);
    // strobe ends first; direction (strobe style only), data and select hold on
    ds_o = ~style_i;
    if (!style_i) rw_o = 1'b1;
    wt(6);
    rw_o = 1'b1;
    drv = 1'b0; cs_n_o = 1'b1;
    wt(6);
  endtask
endmodule
`default_nettype wire

// *** hdl/rtcp_host_port.sv ***
// multiplexed host port, storage and pin control of the clock device
`timescale 1ns/10ps
`default_nettype none
`include "rtcp_params.svh"
module rtcp_host_port
  import rtcp_pkg::*;
#(
  parameter int unsigned WIPE_CYC = `RTCP_WIPE_CYC
) (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       reset_n_i,
  // device reset pin and straps
  input  wire logic       dev_reset_n_i,
  input  wire logic       bus_style_select_i,
  input  wire logic       supply_valid_i,
  // multiplexed host bus
  input  wire logic [7:0] muxed_addr_data_lines_i,
  output logic      [7:0] muxed_addr_data_lines_o,
  output logic            muxed_addr_data_lines_oe_n_o,
  input  wire logic       address_latch_strobe_i,
  input  wire logic       data_strobe_input_i,
  input  wire logic       rd_wr_n_i,
  input  wire logic       chip_sel_n_i,
  input  wire logic       upper_ram_select_i,
  // timekeeping core events and taps, calendar counting stays there
  input  wire logic       periodic_evt_i,
  input  wire logic       alarm_evt_i,
  input  wire logic       update_evt_i,
  input  wire logic [15:0] divider_taps_i,
  input  wire logic       crystal_input_one_i,
  // pins
  input  wire logic       storage_wipe_n_i,
  output logic            irq_n_o,
  output logic            irq_n_oe_n_o,
  output logic            square_wave_out_o
);
  // split style: data strobe is read strobe, direction is write strobe
  typedef struct packed {
    rtcp_state_t state;
    logic [7:0]  addr;
    logic        upper;
    logic [7:0]  dout;
    logic        oe_n;
    logic [7:0]  reg_a;
    logic [7:0]  reg_b;
    logic [7:0]  reg_c;
    logic        irq_n;
    logic        irq_oe_n;
    logic        square_wave_out;
    logic [23:0] wipe_cnt;
    logic        wiping;
    logic [7:0]  wipe_idx;
    logic        as_d;
    logic        ds_d;
    logic        rw_d;
    logic        sty;
    logic        sty_ok;
  } rtcp_st_t;
  rtcp_st_t st_r;
  rtcp_st_t st_nxt;

  logic [7:0] ram_lo [0:`RTCP_RAM_LO_BYTES-1];
  logic [7:0] ram_hi [0:`RTCP_RAM_HI_BYTES-1];
  logic [7:0] ad_s;
  logic       as_s;
  logic       ds_s;
  logic       rw_s;
  logic       cs_n_s;
  logic       up_s;
  logic       wipe_n_s;
  logic       wr_lo;
  logic       wr_hi;
  logic [7:0] wr_idx;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic       flags_any;
  logic       rate_bit;
  logic       xtal_s;

  // every host pin goes through the three-stage filter
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_ad
      rtcp_sync u_sync (
        .sys_clk_i (sys_clk_i),
        .reset_n_i (reset_n_i),
        .pin_i     (muxed_addr_data_lines_i[gi]),
        .level_o   (ad_s[gi])
      );
    end
  endgenerate
  rtcp_sync u_as (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .pin_i(address_latch_strobe_i), .level_o(as_s));
  rtcp_sync u_ds (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .pin_i(data_strobe_input_i), .level_o(ds_s));
  rtcp_sync u_rw (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .pin_i(rd_wr_n_i), .level_o(rw_s));
  rtcp_sync u_cs (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .pin_i(chip_sel_n_i), .level_o(cs_n_s));
  rtcp_sync u_up (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .pin_i(upper_ram_select_i), .level_o(up_s));
  rtcp_sync u_wp (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .pin_i(storage_wipe_n_i), .level_o(wipe_n_s));
  rtcp_sync u_xt (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .pin_i(crystal_input_one_i), .level_o(xtal_s));

  // read mux: control registers sit in the low page only
  always_comb begin
    rd_data = ram_lo[st_r.addr];
    if (st_r.upper) begin
      rd_data = ram_hi[st_r.addr[6:0]];
    end else if (st_r.addr == `RTCP_ADDR_A) begin
      rd_data = st_r.reg_a;
    end else if (st_r.addr == `RTCP_ADDR_B) begin
      rd_data = st_r.reg_b;
    end else if (st_r.addr == `RTCP_ADDR_C) begin
      rd_data = st_r.reg_c;
    end
  end

  // square-wave tap pick: taps indexed by rate field
  assign rate_bit = divider_taps_i[st_r.reg_a[3:0]];

  // next-state logic of the whole port
  always_comb begin
    st_nxt      = st_r;
    wr_lo       = 1'b0;
    wr_hi       = 1'b0;
    wr_idx      = st_r.addr;
    wr_data     = ad_s;
    st_nxt.as_d = as_s;
    st_nxt.ds_d = ds_s;
    st_nxt.rw_d = rw_s;
    // style caught once after release; later changes ignored
    if (!st_r.sty_ok) begin
      st_nxt.sty    = bus_style_select_i;
      st_nxt.sty_ok = 1'b1;
    end
    // address latch independent of chip select
    if (st_r.as_d && !as_s && dev_reset_n_i) begin
      st_nxt.addr  = ad_s;
      st_nxt.upper = up_s;
      st_nxt.oe_n  = 1'b1;
      st_nxt.state = RTCP_ADDR;
    end else begin
      case (st_r.state)
        RTCP_IDLE: begin
          st_nxt.oe_n = 1'b1;
        end
        RTCP_ADDR: begin
          if (!cs_n_s && dev_reset_n_i) begin
            if (st_r.sty) begin
              // strobe style: direction pin sets read or write
              if (!st_r.ds_d && ds_s && rw_s) begin
                st_nxt.state = RTCP_RD;
                st_nxt.dout  = rd_data;
                st_nxt.oe_n  = 1'b0;
              end else if (st_r.ds_d && !ds_s && !rw_s) begin
                st_nxt.state = RTCP_WR;
              end
            end else begin
              if (st_r.ds_d && !ds_s) begin
                st_nxt.state = RTCP_RD;
                st_nxt.dout  = rd_data;
                st_nxt.oe_n  = 1'b0;
              end else if (!st_r.rw_d && rw_s) begin
                st_nxt.state = RTCP_WR;
              end
            end
          end
        end
        RTCP_RD: begin
          // read ends at strobe fall (strobe style) or rise (split style)
          if ((st_r.sty && st_r.ds_d && !ds_s) || (!st_r.sty && !st_r.ds_d && ds_s)
              || cs_n_s) begin
            st_nxt.state = RTCP_IDLE;
            st_nxt.oe_n  = 1'b1;
            if (!st_r.upper && st_r.addr == `RTCP_ADDR_C) begin
              st_nxt.reg_c    = 8'h00;
              st_nxt.irq_oe_n = 1'b1;
            end
          end
        end
        RTCP_WR: begin
          // write blocked while main supply is gone
          if (supply_valid_i) begin
            if (st_r.upper) begin
              wr_hi = 1'b1;
            end else if (st_r.addr == `RTCP_ADDR_A) begin
              st_nxt.reg_a = ad_s;
            end else if (st_r.addr == `RTCP_ADDR_B) begin
              st_nxt.reg_b = ad_s;
            end else if (st_r.addr == `RTCP_ADDR_C) begin
              st_nxt.reg_c[`RTCP_C_PTE] = ad_s[`RTCP_C_PTE];
            end else if (st_r.addr != `RTCP_ADDR_D) begin
              wr_lo = 1'b1;
            end
          end
          st_nxt.state = RTCP_IDLE;
        end
        default: st_nxt.state = RTCP_IDLE;
      endcase
    end
    // event flags set, winning over a clearing read
    if (periodic_evt_i) begin
      st_nxt.reg_c[`RTCP_C_PF] = 1'b1;
    end
    if (alarm_evt_i) begin
      st_nxt.reg_c[`RTCP_C_AF] = 1'b1;
    end
    if (update_evt_i) begin
      st_nxt.reg_c[`RTCP_C_UF] = 1'b1;
    end
    // drive interrupt low on any enabled flag
    // judged on next flags, so a clearing read is not undone at once
    flags_any = (st_nxt.reg_c[`RTCP_C_PF] & st_nxt.reg_b[`RTCP_B_PIE])
              | (st_nxt.reg_c[`RTCP_C_AF] & st_nxt.reg_b[`RTCP_B_AIE])
              | (st_nxt.reg_c[`RTCP_C_UF] & st_nxt.reg_b[`RTCP_B_UIE]);
    if (flags_any) begin
      st_nxt.reg_c[`RTCP_C_IRQF] = 1'b1;
      st_nxt.irq_oe_n            = 1'b0;
    end
    st_nxt.irq_n = 1'b0;
    // square wave selection
    if (!st_r.reg_b[`RTCP_B_SQUARE_WAVE_ENABLE_BIT] || !supply_valid_i) begin
      st_nxt.square_wave_out = 1'b0;
    end else if (st_r.reg_a[6:4] == `RTCP_DIV_PASS && st_r.reg_c[`RTCP_C_PTE]) begin
      st_nxt.square_wave_out = xtal_s;
    end else begin
      st_nxt.square_wave_out = (st_r.reg_a[3:0] == 4'h0) ? 1'b0 : rate_bit;
    end
    // wipe qualifier: continuous low with supply present
    if (wipe_n_s || !supply_valid_i) begin
      st_nxt.wipe_cnt = '0;
    end else if (st_r.wipe_cnt < WIPE_CYC[23:0]) begin
      st_nxt.wipe_cnt = st_r.wipe_cnt + 24'h000001;
    end else if (!st_r.wiping && st_r.wipe_idx == 8'h00) begin
      st_nxt.wiping = 1'b1;
    end
    // walk storage bytes past the clock registers
    if (st_r.wiping) begin
      wr_lo   = 1'b1;
      wr_idx  = st_r.wipe_idx + 8'(`RTCP_REG_BYTES);
      wr_data = `RTCP_WIPE_VAL;
      st_nxt.wipe_idx = st_r.wipe_idx + 8'h01;
      if (st_r.wipe_idx == 8'(`RTCP_RAM_LO_BYTES - `RTCP_REG_BYTES - 1)) begin
        st_nxt.wiping = 1'b0;
      end
    end else if (wipe_n_s) begin
      st_nxt.wipe_idx = 8'h00;
    end
    // device reset pin: release interrupt, drop access, clear bits
    if (!dev_reset_n_i) begin
      st_nxt.state    = RTCP_IDLE;
      st_nxt.oe_n     = 1'b1;
      st_nxt.irq_oe_n = 1'b1;
      st_nxt.reg_b    = st_r.reg_b & `RTCP_B_RST_MASK;
      st_nxt.reg_c    = st_r.reg_c & 8'h0f;
    end
  end

  // storage arrays, no reset
  always_ff @(posedge sys_clk_i) begin
    if (wr_lo) begin
      ram_lo[wr_idx] <= wr_data;
    end
    if (wr_hi) begin
      ram_hi[st_r.addr[6:0]] <= ad_s;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r          <= '0;
      st_r.state    <= RTCP_IDLE;
      st_r.oe_n     <= 1'b1;
      st_r.irq_oe_n <= 1'b1;
      st_r.as_d     <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign muxed_addr_data_lines_o      = st_r.dout;
  assign muxed_addr_data_lines_oe_n_o = st_r.oe_n;
  assign irq_n_o                      = st_r.irq_n;
  assign irq_n_oe_n_o                 = st_r.irq_oe_n;
  assign square_wave_out_o            = st_r.square_wave_out;

  // checks
  property p_irq_on_flag;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (flags_any && dev_reset_n_i) |=> !irq_n_oe_n_o;
  endproperty
  a_irq_on_flag: assert property (p_irq_on_flag) else $error("irq not driven");
  property p_sqw_low;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      !st_r.reg_b[`RTCP_B_SQUARE_WAVE_ENABLE_BIT] |=> !square_wave_out_o;
  endproperty
  a_sqw_low: assert property (p_sqw_low) else $error("square wave not low");
  property p_rst_release;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      !dev_reset_n_i |=> irq_n_oe_n_o && muxed_addr_data_lines_oe_n_o;
  endproperty
  a_rst_release: assert property (p_rst_release) else $error("reset not honoured");
  property p_nowrite_nosupply;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (!supply_valid_i && !st_r.wiping) |-> !wr_hi && !wr_lo;
  endproperty
  a_nowrite_nosupply: assert property (p_nowrite_nosupply) else $error("write in fail");
  property p_read_clears;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (st_r.state == RTCP_RD && st_nxt.state == RTCP_IDLE && !st_r.upper
       && st_r.addr == `RTCP_ADDR_C && !flags_any && !periodic_evt_i
       && !alarm_evt_i && !update_evt_i && dev_reset_n_i)
      |=> st_r.reg_c[7:4] == 4'h0 && irq_n_oe_n_o;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("flag read no clear");
  property p_alarm_flag;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (alarm_evt_i && dev_reset_n_i) |=> st_r.reg_c[`RTCP_C_AF];
  endproperty
  a_alarm_flag: assert property (p_alarm_flag) else $error("alarm flag lost");
  property p_wipe_wait;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      $rose(st_r.wiping) |-> st_r.wipe_cnt >= WIPE_CYC[23:0];
  endproperty
  a_wipe_wait: assert property (p_wipe_wait) else $error("wipe too early");
  property p_wipe_value;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      st_r.wiping |-> wr_data == `RTCP_WIPE_VAL && wr_idx >= 8'(`RTCP_REG_BYTES);
  endproperty
  a_wipe_value: assert property (p_wipe_value) else $error("wipe hits registers");
  c_read: cover property (@(posedge sys_clk_i) st_r.state == RTCP_RD);
  c_write: cover property (@(posedge sys_clk_i) st_r.state == RTCP_WR);
  c_wipe: cover property (@(posedge sys_clk_i) st_r.wiping);
endmodule
`default_nettype wire

// *** hdl/rtcp_params.svh ***
// constants for the real-time clock host port block
`ifndef RTCP_PARAMS_SVH
`define RTCP_PARAMS_SVH
`define RTCP_CLK_MHZ        125
`define RTCP_WIPE_MS        125
`define RTCP_WIPE_CYC       (`RTCP_WIPE_MS * `RTCP_CLK_MHZ * 1000)
`define RTCP_RAM_LO_BYTES   256
`define RTCP_RAM_HI_BYTES   128
`define RTCP_REG_BYTES      14
`define RTCP_ADDR_A         8'h0a
`define RTCP_ADDR_B         8'h0b
`define RTCP_ADDR_C         8'h0c
`define RTCP_ADDR_D         8'h0d
`define RTCP_B_SQUARE_WAVE_ENABLE_BIT         3
`define RTCP_B_PIE          6
`define RTCP_B_AIE          5
`define RTCP_B_UIE          4
`define RTCP_C_IRQF         7
`define RTCP_C_PF           6
`define RTCP_C_AF           5
`define RTCP_C_UF           4
`define RTCP_C_PTE          0
`define RTCP_B_RST_MASK     8'h8f
`define RTCP_DIV_PASS       3'b011
`define RTCP_WIPE_VAL       8'hff
`endif

// *** hdl/rtcp_pkg.sv ***
// types shared by the real-time clock host port block
package rtcp_pkg;
  typedef enum logic [3:0] {
    RTCP_IDLE = 4'b0001,
    RTCP_ADDR = 4'b0010,
    RTCP_RD   = 4'b0100,
    RTCP_WR   = 4'b1000
  } rtcp_state_t;
endpackage

// *** hdl/rtcp_sync.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module rtcp_sync (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  // pin in, clean level out
  input  wire logic pin_i,
  output logic      level_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } rtcp_sync_st_t;
  rtcp_sync_st_t st_r;
  rtcp_sync_st_t st_nxt;

  // level moves only when second and third stage agree
  always_comb begin
    st_nxt     = st_r;
    st_nxt.s1  = pin_i;
    st_nxt.s2  = st_r.s1;
    st_nxt.s3  = st_r.s2;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.lvl = st_r.s3;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_o = st_r.lvl;
endmodule
`default_nettype wire
